// ===== logic/transceiver_power_mode_control.sv
// Purpose: power state sequencer of an RF transceiver
// Assumes: pins asynchronous to REF_CLK, register port one-cycle strobes
// Notes: mode changes inside the active state take effect in one cycle
//
// What this block does
// - main enable high: regulators, oscillator, host clock
// - wake only: sleep, aux supply and slow clock
// - both pins low: everything off
// - wake rising edge starts supplies like main
// - no main within window: back to off
// - host raises main; device then stays active
// - fast clock only after settle, then ready
// - active sub-mode taken from control register
// - standby bit: tx and rx off, clock runs
// - bits 5 and 1 clear: RF off
// - bit 1 alone: receiver only
// - bit 5: transmitter and receiver on
// - 3.3 V codes, regulator 00 or 07
// - 5 V codes, regulator always 07
// - bit 0 selects 5 V supply, default
`timescale 1ns/1ns
module transceiver_power_mode_control #(
   parameter int SETTLE_CYCLES = pmc_pkg::SETTLE_CYC,
   parameter int WAKE_WINDOW_CYCLES = pmc_pkg::WAKE_WINDOW_CYC,
   parameter int TW = 16
) (
   // clock and reset
   input wire logic REF_CLK,
   input wire logic ARST_N,
   // enable pins
   input wire logic MAIN_EN,
   input wire logic WAKE_EN,
   // register port
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [7:0] REG_RDATA,
   // power controls
   output logic REGULATOR_EN,
   output logic OSC_EN,
   output logic AUX_SUPPLY_EN,
   output logic HOST_CLK_EN,
   output logic HOST_CLK_FAST,
   output logic TX_EN,
   output logic RX_EN,
   output logic TX_HALF_POWER,
   output logic SUPPLY_5V,
   output logic COMM_READY,
   output logic [2:0] POWER_STATE
);

   initial begin
      if (SETTLE_CYCLES < 1 || SETTLE_CYCLES >= (1 << TW)) $error("SETTLE_CYCLES does not fit");
      if (WAKE_WINDOW_CYCLES < 1 || WAKE_WINDOW_CYCLES >= (1 << TW)) $error("WAKE_WINDOW_CYCLES does not fit");
   end

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   logic rst_meta_r;
   logic rst_n;

   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         rst_meta_r <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n <= rst_meta_r;
      end
   end

   // ----------------------------------------------------------------
   // pin sampling
   // ----------------------------------------------------------------
   logic [1:0] pins_s;
   logic main_s;
   logic wake_s;
   logic wake_prev_r;
   logic wake_rise;

   pin_sync #(.W(2)) u_sync (
      .clk(REF_CLK),
      .rst_n(rst_n),
      .d({WAKE_EN, MAIN_EN}),
      .q(pins_s)
   );

   assign main_s = pins_s[0];
   assign wake_s = pins_s[1];
   // a pin already high at reset release counts as a rising edge
   assign wake_rise = wake_s && !wake_prev_r;

   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) wake_prev_r <= 1'b0;
      else wake_prev_r <= wake_s;
   end

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   pmc_timer_if #(.TW(TW)) tif ();

   countdown_timer #(.TW(TW)) u_timer (
      .clk(REF_CLK),
      .rst_n(rst_n),
      .t(tif)
   );

   pmc_pkg::pwr_state_t state_r;
   pmc_pkg::pwr_state_t state_nxt;
   logic from_wake_r;
   logic from_wake_nxt;
   logic drop_to_sleep;

   // main low: wake level decides between sleep and off
   assign drop_to_sleep = wake_s;

   always_comb begin
      state_nxt = state_r;
      from_wake_nxt = from_wake_r;
      unique case (state_r)
         pmc_pkg::PWR_OFF: begin
            if (main_s) begin
               state_nxt = pmc_pkg::PWR_START;
               from_wake_nxt = 1'b0;
            end else if (wake_rise) begin
               state_nxt = pmc_pkg::PWR_START;
               from_wake_nxt = 1'b1;
            end
         end
         pmc_pkg::PWR_SLEEP: begin
            if (main_s) begin
               state_nxt = pmc_pkg::PWR_START;
               from_wake_nxt = 1'b0;
            end else if (!wake_s) begin
               state_nxt = pmc_pkg::PWR_OFF;
            end
         end
         pmc_pkg::PWR_START: begin
            if (!main_s && !from_wake_r) begin
               state_nxt = drop_to_sleep ? pmc_pkg::PWR_SLEEP : pmc_pkg::PWR_OFF;
            end else if (tif.expired) begin
               state_nxt = main_s ? pmc_pkg::PWR_ACTIVE : pmc_pkg::PWR_WAKE_WAIT;
            end
         end
         pmc_pkg::PWR_WAKE_WAIT: begin
            if (main_s) begin
               state_nxt = pmc_pkg::PWR_ACTIVE;
               from_wake_nxt = 1'b0;
            end else if (tif.expired) begin
               state_nxt = pmc_pkg::PWR_OFF;
            end
         end
         pmc_pkg::PWR_ACTIVE: begin
            if (!main_s) begin
               state_nxt = drop_to_sleep ? pmc_pkg::PWR_SLEEP : pmc_pkg::PWR_OFF;
            end
         end
         default: state_nxt = pmc_pkg::PWR_OFF;
      endcase
   end

   // timer reloads on entry to the settle and wake-window states
   assign tif.load = (state_nxt != state_r) &&
                     (state_nxt == pmc_pkg::PWR_START || state_nxt == pmc_pkg::PWR_WAKE_WAIT);
   assign tif.count = (state_nxt == pmc_pkg::PWR_START) ? TW'(SETTLE_CYCLES) : TW'(WAKE_WINDOW_CYCLES);

   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= pmc_pkg::PWR_OFF;
         from_wake_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         from_wake_r <= from_wake_nxt;
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [7:0] csc_r;
   logic [7:0] regc_r;
   logic [7:0] rdata_r;
   logic ready;
   logic regs_default;
   logic wr_csc;
   logic wr_regc;
   logic regc_ok;
   logic [7:0] status;
   logic [7:0] rd_mux;

   // host writes and reads control registers only once the fast clock is out; status reads any time
   assign ready = (state_r == pmc_pkg::PWR_ACTIVE) || (state_r == pmc_pkg::PWR_WAKE_WAIT);
   // supplies off: register contents are lost and return to defaults
   assign regs_default = (state_r == pmc_pkg::PWR_OFF) || (state_r == pmc_pkg::PWR_SLEEP);
   assign wr_csc = REG_WR && ready && (REG_ADDR == pmc_pkg::CSC_ADDR);
   assign wr_regc = REG_WR && ready && (REG_ADDR == pmc_pkg::REGC_ADDR);

   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         csc_r <= pmc_pkg::CSC_RESET;
         regc_r <= pmc_pkg::REGC_RESET;
      end else if (regs_default) begin
         csc_r <= pmc_pkg::CSC_RESET;
         regc_r <= pmc_pkg::REGC_RESET;
      end else begin
         if (wr_csc) csc_r <= REG_WDATA;
         if (wr_regc) regc_r <= REG_WDATA;
      end
   end

   // ----------------------------------------------------------------
   // sub-mode decode
   // ----------------------------------------------------------------
   logic active;
   logic stby;
   logic txrx;
   logic rx_only;
   logic supply5v;

   assign active = (state_r == pmc_pkg::PWR_ACTIVE);
   assign stby = csc_r[pmc_pkg::CSC_STANDBY_BIT];
   assign txrx = !stby && csc_r[pmc_pkg::CSC_TXRX_BIT];
   assign rx_only = !stby && !csc_r[pmc_pkg::CSC_TXRX_BIT] && csc_r[pmc_pkg::CSC_RXONLY_BIT];
   assign supply5v = csc_r[pmc_pkg::CSC_SUPPLY5V_BIT];
   // high when the regulator code belongs to the chosen mode
   assign regc_ok = (regc_r == pmc_pkg::regc_expected(supply5v, txrx));

   assign status = {2'h0, wake_s, regc_ok, ready, 3'(state_r)};
   assign rd_mux = (REG_ADDR == pmc_pkg::STAT_ADDR) ? status :
                   !ready ? 8'h00 :
                   (REG_ADDR == pmc_pkg::CSC_ADDR) ? csc_r :
                   (REG_ADDR == pmc_pkg::REGC_ADDR) ? regc_r : 8'h00;

   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) rdata_r <= 8'h00;
      else rdata_r <= REG_RD ? rd_mux : 8'h00;
   end

   assign REG_RDATA = rdata_r;

   // ----------------------------------------------------------------
   // power outputs
   // ----------------------------------------------------------------
   logic [8:0] out_nxt;
   logic [8:0] out_r;
   logic on_nxt;
   logic slow_nxt;
   logic fast_nxt;
   logic act_nxt;

   assign on_nxt = (state_nxt == pmc_pkg::PWR_START) || fast_nxt;
   assign slow_nxt = (state_nxt == pmc_pkg::PWR_SLEEP) || (state_nxt == pmc_pkg::PWR_START);
   assign fast_nxt = (state_nxt == pmc_pkg::PWR_ACTIVE) || (state_nxt == pmc_pkg::PWR_WAKE_WAIT);
   assign act_nxt = (state_nxt == pmc_pkg::PWR_ACTIVE);
   // mode 1 and standby leave both RF paths off; clock keeps running
   assign out_nxt = {
      fast_nxt,                                  // ready
      act_nxt && txrx && csc_r[pmc_pkg::CSC_HALF_BIT], // half power
      act_nxt && (txrx || rx_only),
      act_nxt && txrx,
      fast_nxt,                                  // fast clock select
      slow_nxt || fast_nxt,                      // host clock
      slow_nxt || fast_nxt,                      // aux supply
      on_nxt,                                    // oscillator
      on_nxt                                     // regulators
   };

   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) out_r <= 9'h000;
      else out_r <= out_nxt;
   end

   assign COMM_READY = out_r[8];
   assign TX_HALF_POWER = out_r[7];
   assign RX_EN = out_r[6];
   assign TX_EN = out_r[5];
   assign HOST_CLK_FAST = out_r[4];
   assign HOST_CLK_EN = out_r[3];
   assign AUX_SUPPLY_EN = out_r[2];
   assign OSC_EN = out_r[1];
   assign REGULATOR_EN = out_r[0];
   assign SUPPLY_5V = supply5v;
   assign POWER_STATE = 3'(state_r);

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   logic [TW-1:0] ww_cnt_r;

   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) ww_cnt_r <= '0;
      else if (state_r == pmc_pkg::PWR_WAKE_WAIT) ww_cnt_r <= ww_cnt_r + 1'b1;
      else ww_cnt_r <= '0;
   end

   chk_off_quiet: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      (state_r == pmc_pkg::PWR_OFF) |-> (!REGULATOR_EN && !OSC_EN && !AUX_SUPPLY_EN && !HOST_CLK_EN && !TX_EN))
      else $error("power down left a supply or clock on");

   chk_sleep_aux: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      (state_r == pmc_pkg::PWR_SLEEP) |-> (AUX_SUPPLY_EN && HOST_CLK_EN && !HOST_CLK_FAST && !OSC_EN && !RX_EN))
      else $error("sleep outputs wrong");

   chk_main_starts: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      (state_r == pmc_pkg::PWR_OFF && main_s) |=> (state_r == pmc_pkg::PWR_START && REGULATOR_EN && OSC_EN))
      else $error("main enable did not start supplies");

   chk_wake_edge: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      (state_r == pmc_pkg::PWR_OFF && !main_s && wake_rise) |=> (REGULATOR_EN && OSC_EN && from_wake_r))
      else $error("wake edge did not start supplies");

   chk_wake_window: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      ww_cnt_r <= TW'(WAKE_WINDOW_CYCLES))
      else $error("wake window overran");

   chk_main_holds: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      (state_r != pmc_pkg::PWR_OFF && state_r != pmc_pkg::PWR_SLEEP && main_s && tif.expired)
      |=> (state_r == pmc_pkg::PWR_ACTIVE) ##1 (!$past(main_s) || state_r == pmc_pkg::PWR_ACTIVE))
      else $error("device left active with main high");

   chk_fast_after_settle: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      $rose(HOST_CLK_FAST) |-> ($past(tif.expired) && $past(state_r) == pmc_pkg::PWR_START))
      else $error("fast clock before settle");

   chk_standby_off: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      (state_r == pmc_pkg::PWR_ACTIVE && state_nxt == pmc_pkg::PWR_ACTIVE && stby)
      |=> (!TX_EN && !RX_EN && HOST_CLK_FAST))
      else $error("standby left RF on");

   chk_mode1_off: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      (!csc_r[pmc_pkg::CSC_TXRX_BIT] && !csc_r[pmc_pkg::CSC_RXONLY_BIT] && $stable(csc_r)) |-> (!TX_EN && !RX_EN))
      else $error("mode 1 left RF on");

   chk_rx_only: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      (state_r == pmc_pkg::PWR_ACTIVE && state_nxt == pmc_pkg::PWR_ACTIVE && rx_only) |=> (RX_EN && !TX_EN))
      else $error("receive-only mode wrong");

   chk_txrx_on: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      (state_r == pmc_pkg::PWR_ACTIVE && state_nxt == pmc_pkg::PWR_ACTIVE && txrx) |=> (RX_EN && TX_EN))
      else $error("transmit mode wrong");

   chk_reg_code: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      (regc_r == pmc_pkg::REGC_CODE_TX) |-> (regc_ok == (supply5v || txrx)))
      else $error("5 V regulator code flagged");

endmodule

// ===== logic/pmc_pkg.sv
// Purpose: shared constants and types of the transceiver power mode control
// Assumes: 125 MHz reference clock, 8-bit register port
// Notes: register codes and bit positions of the chip power state control
package pmc_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0] CSC_ADDR = 8'h00;
   localparam logic [7:0] REGC_ADDR = 8'h0B;
   localparam logic [7:0] STAT_ADDR = 8'h3F;
   localparam logic [7:0] CSC_RESET = 8'h01;
   localparam logic [7:0] REGC_RESET = 8'h07;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int CSC_STANDBY_BIT = 7;
   localparam int CSC_TXRX_BIT = 5;
   localparam int CSC_HALF_BIT = 4;
   localparam int CSC_RXONLY_BIT = 1;
   localparam int CSC_SUPPLY5V_BIT = 0;
   localparam int STAT_STATE_LSB = 0;
   localparam int STAT_READY_BIT = 3;
   localparam int STAT_REGC_OK_BIT = 4;
   localparam int STAT_WAKE_BIT = 5;
   localparam logic [7:0] REGC_CODE_LOW = 8'h00;
   localparam logic [7:0] REGC_CODE_TX = 8'h07;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 125;
   localparam int WAKE_WINDOW_US = 100;
   localparam int WAKE_WINDOW_CYC = WAKE_WINDOW_US * CLK_MHZ;
   localparam int SETTLE_US = 200;
   localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;

   typedef enum logic [2:0] {PWR_OFF, PWR_SLEEP, PWR_START, PWR_WAKE_WAIT, PWR_ACTIVE} pwr_state_t;

   // regulator code that belongs to the selected supply and mode
   function automatic logic [7:0] regc_expected(input logic supply5v, input logic txrx);
      regc_expected = (supply5v || txrx) ? REGC_CODE_TX : REGC_CODE_LOW;
   endfunction

endpackage

// ===== logic/pmc_timer_if.sv
// Purpose: load and expiry signals between sequencer and countdown timer
// Assumes: one clock domain
// Notes: load is a one-cycle pulse beside count
`timescale 1ns/1ns
interface pmc_timer_if #(parameter int TW = 16);
   logic load;
   logic [TW-1:0] count;
   logic expired;
   modport ctl (output load, output count, input expired);
   modport tmr (input load, input count, output expired);
endinterface

// ===== logic/pin_sync.sv
// Purpose: two-flop synchroniser for enable pins
// Assumes: pins are slow levels
// Notes: resets to zero so pins read low after reset
`timescale 1ns/1ns
module pin_sync #(parameter int W = 2) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= '0;
         q <= '0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule

// ===== logic/countdown_timer.sv
// Purpose: one-shot countdown used for settle time and wake window
// Assumes: count is at least 1
// Notes: expired is high from count cycles after load until next load
`timescale 1ns/1ns
module countdown_timer #(parameter int TW = 16) (
   input wire logic clk,
   input wire logic rst_n,
   pmc_timer_if.tmr t
);
   logic [TW-1:0] cnt_r;
   logic run_r;

   initial begin
      if (TW < 2 || TW > 31) $error("countdown_timer: TW out of range");
   end

   assign t.expired = run_r && (cnt_r == '0);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= '0;
         run_r <= 1'b0;
      end else if (t.load) begin
         cnt_r <= t.count - 1'b1;
         run_r <= 1'b1;
      end else if (run_r && cnt_r != '0) begin
         cnt_r <= cnt_r - 1'b1;
      end
   end
endmodule

// ===== dv/host_model.sv
// Purpose: host controller model driving the enable pins and the register port
// Assumes: one clock, the block samples everything on the rising edge
// Notes: the pin spacing is scaled down like the other long counts
`timescale 1ns/1ns
module host_model #(
   parameter int GAP_CYC = 10
) (
   // clock
   input wire logic clk,
   // enable pins
   output logic main_en,
   output logic wake_en,
   // register port
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [7:0] reg_rdata
);
   int cyc;
   int last_pin;

   initial begin
      main_en = 1'b0;
      wake_en = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      cyc = 0;
      last_pin = -GAP_CYC;
   end

   always @(posedge clk) cyc <= cyc + 1;

   // ----------------------------------------------------------------
   // enable pins
   // ----------------------------------------------------------------
   // a host that only drives main just never calls this for the wake pin
   task automatic set_pin(input logic is_wake, input logic v);
      @(posedge clk);
      while (cyc - last_pin < GAP_CYC) @(posedge clk);
      if (is_wake) wake_en <= v;
      else main_en <= v;
      last_pin = cyc;
   endtask

   // ----------------------------------------------------------------
   // register port
   // ----------------------------------------------------------------
   // released address and data lines are inverted so stale values never look valid
   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask

   task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      @(posedge clk);
      d = reg_rdata;
   endtask
endmodule

// ===== dv/tb.sv
// Purpose: self-checking bench of the transceiver power mode control
// Assumes: settle and wake window shortened through parameters
// Notes: pwr packs regulator, osc, aux, host clock, fast, tx, rx, half
`timescale 1ns/1ns
module tb;
   localparam int SETTLE = 20;
   localparam int WINDOW = 30;
   localparam int LIMIT = 20000;

   logic ref_clk;
   logic arst_n;
   logic main_en, wake_en, reg_wr, reg_rd;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic regulator_en, osc_en, aux_en, hclk_en, hclk_fast, tx_en, rx_en, tx_half;
   logic supply_5v, comm_ready;
   logic [2:0] power_state;
   logic [7:0] pwr;
   int error_cnt;
   int tests_run;
   int cycles;

   assign pwr = {regulator_en, osc_en, aux_en, hclk_en, hclk_fast, tx_en, rx_en, tx_half};

   initial ref_clk = 1'b0;
   always #4 ref_clk = ~ref_clk;

   transceiver_power_mode_control #(.SETTLE_CYCLES(SETTLE), .WAKE_WINDOW_CYCLES(WINDOW), .TW(16))
   transceiver_power_mode_control_inst (
      .REF_CLK(ref_clk), .ARST_N(arst_n), .MAIN_EN(main_en), .WAKE_EN(wake_en),
      .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
      .REG_RDATA(reg_rdata), .REGULATOR_EN(regulator_en), .OSC_EN(osc_en),
      .AUX_SUPPLY_EN(aux_en), .HOST_CLK_EN(hclk_en), .HOST_CLK_FAST(hclk_fast),
      .TX_EN(tx_en), .RX_EN(rx_en), .TX_HALF_POWER(tx_half), .SUPPLY_5V(supply_5v),
      .COMM_READY(comm_ready), .POWER_STATE(power_state));

   host_model #(.GAP_CYC(10)) host_model_inst (
      .clk(ref_clk), .main_en(main_en), .wake_en(wake_en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   // bounded wait so a block that never gets ready cannot hang the run
   task automatic wait_ready(output int n);
      n = 0;
      while (comm_ready !== 1'b1 && n < 200) begin
         tick(1);
         n++;
      end
   endtask

   // pin change reaches state and outputs three edges later, fast clock after settle
   task automatic startup(input logic is_wake, input logic [2:0] st);
      int n;
      host_model_inst.set_pin(is_wake, 1'b1);
      tick(2);
      chk(pwr, 8'h00, "outputs before state flop");
      tick(1);
      chk({4'h0, comm_ready, power_state}, 8'h02, "start state");
      chk(pwr, 8'hF0, "supplies on, slow clock");
      wait_ready(n);
      chk(8'(n >= SETTLE && n <= SETTLE + 3), 8'h01, "settle length");
      chk(pwr[7:3], 5'h1F, "fast clock");
      tick(1);
      chk({5'h00, power_state}, {5'h00, st}, "state after settle");
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      logic [7:0] d;
      chk(pwr, 8'h00, "reset outputs");
      chk({4'h0, supply_5v, power_state}, 8'h08, "reset state");
      host_model_inst.reg_read(8'h00, d);
      chk(d, 8'h00, "control hidden while off");
      $display("test reset done");
   endtask

   task automatic t_main_up();
      logic [7:0] d;
      startup(1'b0, 3'd4);
      host_model_inst.reg_read(8'h00, d);
      chk(d, 8'h01, "control default");
      host_model_inst.reg_read(8'h0B, d);
      chk(d, 8'h07, "regulator default");
      host_model_inst.reg_write(8'h10, 8'h5A);
      host_model_inst.reg_read(8'h10, d);
      chk(d, 8'h00, "unmapped reads zero");
      chk(pwr, 8'hF8, "mode 1 at default");
      $display("test main start done");
   endtask

   task automatic t_modes();
      logic [7:0] codes [5] = '{8'h80, 8'h00, 8'h02, 8'h30, 8'h20};
      logic [7:0] outs [5] = '{8'hF8, 8'hF8, 8'hFA, 8'hFF, 8'hFE};
      logic [7:0] code;
      logic [7:0] regc;
      logic [7:0] d;
      for (int i = 0; i < 10; i++) begin
         code = codes[i % 5] | 8'(i / 5);
         regc = (outs[i % 5][2] || code[0]) ? 8'h07 : 8'h00;
         host_model_inst.reg_write(8'h00, code);
         host_model_inst.reg_write(8'h0B, regc);
         tick(3);
         chk(pwr, outs[i % 5], "mode outputs");
         chk({7'h00, supply_5v}, 8'(i / 5), "supply select");
         host_model_inst.reg_read(8'h00, d);
         chk(d, code, "control readback");
         host_model_inst.reg_read(8'h3F, d);
         chk(d, 8'h1C, "status with matching regulator code");
      end
      host_model_inst.reg_write(8'h0B, 8'h00);
      host_model_inst.reg_read(8'h3F, d);
      chk(d, 8'h0C, "5 V needs regulator 07");
      $display("test modes done");
   endtask

   task automatic t_sleep();
      logic [7:0] d;
      host_model_inst.set_pin(1'b1, 1'b1);
      host_model_inst.set_pin(1'b0, 1'b0);
      tick(6);
      chk(pwr, 8'h30, "sleep outputs");
      chk({4'h0, comm_ready, power_state}, 8'h01, "sleep state");
      host_model_inst.reg_read(8'h00, d);
      chk(d, 8'h00, "control hidden in sleep");
      host_model_inst.set_pin(1'b1, 1'b0);
      tick(6);
      chk({power_state, pwr[7:3]}, 8'h00, "power down");
      $display("test sleep done");
   endtask

   task automatic t_wake_timeout();
      int n;
      startup(1'b1, 3'd3);
      n = 1;
      while (power_state !== 3'd0 && n < 200) begin
         tick(1);
         n++;
      end
      chk(8'(n >= WINDOW && n <= WINDOW + 3), 8'h01, "wake window length");
      tick(1);
      chk(pwr, 8'h00, "fallback outputs");
      tick(40);
      chk({5'h00, power_state}, 8'h00, "steady wake ignored");
      host_model_inst.set_pin(1'b1, 1'b0);
      $display("test wake timeout done");
   endtask

   task automatic t_wake_keep();
      int n;
      logic [7:0] d;
      host_model_inst.set_pin(1'b1, 1'b1);
      host_model_inst.reg_write(8'h00, 8'h20);
      wait_ready(n);
      host_model_inst.set_pin(1'b0, 1'b1);
      tick(WINDOW + 10);
      chk({4'h0, comm_ready, power_state}, 8'h0C, "stays active");
      host_model_inst.reg_read(8'h00, d);
      chk(d, 8'h01, "early write refused");
      chk(pwr, 8'hF8, "mode 1 after wake start");
      $display("test wake keep done");
   endtask

   // ----------------------------------------------------------------
   // run
   // ----------------------------------------------------------------
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         error_cnt++;
         $display("[ERR] %0t run exceeded cycle limit", $time);
         end_sim();
      end
   end

   initial begin
      error_cnt = 0;
      tests_run = 0;
      cycles = 0;
      arst_n = 1'b0;
      repeat (3) @(posedge ref_clk);
      arst_n <= 1'b1;
      tick(3);
      t_reset();
      t_main_up();
      t_modes();
      t_sleep();
      t_wake_timeout();
      t_wake_keep();
      end_sim();
   end
endmodule
